// File: cca_ccm.v
`timescale 1ns/1ns
`include "cca_consts.vh"

module cca_ccm #(
    parameter IS_WDT = 0
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire [15:0] count,
    input  wire        adv_q,
    input  wire        lo_ovf,
    input  wire        io_line,
    input  wire [7:0]  wdata,
    input  wire        mode_wr,
    input  wire        lo_wr,
    input  wire        hi_wr,
    input  wire        flag_clr,
    input  wire        wdt_active,
    output reg  [7:0]  mode_q,
    output reg  [15:0] cc_q,
    output reg         flag_q,
    output reg  [2:0]  op_q,
    output wire        wdt_trip
);

    function [2:0] cca_decode;
        input [7:0] m;
        begin
            if (!m[`CCA_M_MAT] && !m[`CCA_M_TOG] && !m[`CCA_M_PWM] && (m[`CCA_M_CAPP] || m[`CCA_M_CAPN]))
                cca_decode = `CCA_OP_CAPT;
            else if (m[`CCA_M_CAPP] || m[`CCA_M_CAPN] || !m[`CCA_M_ECOM])
                cca_decode = `CCA_OP_NONE;
            else if (m[`CCA_M_TOG] && m[`CCA_M_PWM])
                cca_decode = `CCA_OP_FREQ;
            else if (m[`CCA_M_PWM])
                cca_decode = m[`CCA_M_PWM16] ? `CCA_OP_PWM16 : `CCA_OP_PWM8;
            else if (m[`CCA_M_MAT] && m[`CCA_M_TOG])
                cca_decode = `CCA_OP_HSO;
            else if (m[`CCA_M_MAT])
                cca_decode = `CCA_OP_SWT;
            else
                cca_decode = `CCA_OP_NONE;
        end
    endfunction

    reg        io_q1;
    reg        io_q2;
    reg [7:0]  mode_d;
    reg [15:0] cc_d;
    reg        flag_set;
    wire       wdt_hold = (IS_WDT != 0) && wdt_active;
    // watchdog forces software timer, keeps only the irq enable
    wire [7:0] eff_mode = wdt_hold ? ((mode_q & `CCA_WDT_MODE_MASK) | `CCA_WDT_MODE_SET) : mode_q;
    wire [2:0] op       = cca_decode(eff_mode);
    wire       rise     = io_q1 & ~io_q2;
    wire       fall     = ~io_q1 & io_q2;
    wire       cap_ev   = (op == `CCA_OP_CAPT) &&
                          ((rise && eff_mode[`CCA_M_CAPP]) || (fall && eff_mode[`CCA_M_CAPN]));
    // compare only right after the counter moved, so one match sets once
    wire       match_ev = adv_q && (count == cc_q) &&
                          ((op == `CCA_OP_SWT) || (op == `CCA_OP_HSO));

    assign wdt_trip = wdt_hold && lo_ovf && (cc_q[15:8] == count[15:8]);

    always @* begin
        mode_d = mode_q;
        cc_d   = cc_q;
        if (mode_wr && !wdt_hold)
            mode_d = wdata;
        if (cap_ev)
            cc_d = count;
        if (lo_wr) begin
            cc_d[7:0]           = wdata;
            mode_d[`CCA_M_ECOM] = 1'b0;
        end
        if (hi_wr) begin
            // watchdog kick reloads deadline from count plus offset
            cc_d[15:8]          = wdt_hold ? (count[15:8] + cc_q[7:0]) : wdata;
            mode_d[`CCA_M_ECOM] = 1'b1;
        end
        flag_set = cap_ev | match_ev;
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            io_q1  <= 1'b0;
            io_q2  <= 1'b0;
            mode_q <= `CCA_MODE_RST;
            cc_q   <= `CCA_CNT_RST;
            flag_q <= 1'b0;
            op_q   <= `CCA_OP_NONE;
        end else begin
            io_q1  <= io_line;
            io_q2  <= io_q1;
            mode_q <= mode_d;
            cc_q   <= cc_d;
            flag_q <= flag_set | (flag_q & ~flag_clr);
            op_q   <= op;
        end
    end

endmodule

// File: cca_consts.vh
`ifndef CCA_CONSTS_VH
`define CCA_CONSTS_VH

// timebase select encodings
`define CCA_TB_DIV12      3'h0
`define CCA_TB_DIV4       3'h1
`define CCA_TB_T0OVF      3'h2
`define CCA_TB_ECI        3'h3
`define CCA_TB_SYSCLK     3'h4
`define CCA_TB_XOSC8      3'h5

// prescaler terminal counts (divide-by minus one)
`define CCA_DIV12_LAST    4'hB
`define CCA_DIV4_LAST     4'h3
`define CCA_DIV_RST       4'h0

// counter values
`define CCA_CNT_RST       16'h0000
`define CCA_CNT_MAX       16'hFFFF
`define CCA_BYTE_MAX      8'hFF
`define CCA_BYTE_RST      8'h00

// module mode register bit positions
`define CCA_M_PWM16       7
`define CCA_M_ECOM        6
`define CCA_M_CAPP        5
`define CCA_M_CAPN        4
`define CCA_M_MAT         3
`define CCA_M_TOG         2
`define CCA_M_PWM         1
`define CCA_M_ECCF        0
`define CCA_MODE_RST      8'h00
`define CCA_WDT_MODE_MASK 8'h01
`define CCA_WDT_MODE_SET  8'h48

// decoded operating modes
`define CCA_OP_NONE       3'h0
`define CCA_OP_CAPT       3'h1
`define CCA_OP_SWT        3'h2
`define CCA_OP_HSO        3'h3
`define CCA_OP_FREQ       3'h4
`define CCA_OP_PWM8       3'h5
`define CCA_OP_PWM16      3'h6

// watchdog state after reset
`define CCA_WDT_RST       1'b1

`endif

// File: cca_ext_model.sv
`timescale 1ns/1ns
module cca_ext_model (
    input  wire       mclk,
    output reg  [2:0] module_io_line,
    output reg        external_count_input,
    output reg        ext_osc_div8
);
    initial begin
        module_io_line = 3'h0;
        external_count_input = 1'b1;
        ext_osc_div8 = 1'b0;
    end
    // three cycles per level leaves margin over the two-cycle minimum
    task io_set(input int idx, input bit val);
        @(negedge mclk) module_io_line[idx] = val;
        repeat (3) @(negedge mclk);
    endtask
    // two cycles low, two high: never faster than a quarter of mclk
    task eci_falls(input int n);
        repeat (n) begin
            @(negedge mclk) external_count_input = 1'b0;
            repeat (2) @(negedge mclk);
            external_count_input = 1'b1;
            @(negedge mclk);
        end
    endtask
    task osc_rises(input int n);
        repeat (n) begin
            @(negedge mclk) ext_osc_div8 = 1'b1;
            repeat (4) @(negedge mclk);
            ext_osc_div8 = 1'b0;
            repeat (3) @(negedge mclk);
        end
    endtask
endmodule

// File: cca_top.v
// Contract
// - sixteen-bit up-counter seen as two bytes
// - low read snapshots high byte, no disturbance
// - timebase select picks six count sources
// - count falling edges on external input
// - synchronise divided external oscillator first
// - wrap FFFF to 0000 sets overflow flag
// - overflow irq only when enabled
// - overflow flag stays until software clears
// - irq needs global and array enables
// - idle with suspend clear keeps running
// - three modules, sixteen-bit register, own line
// - capture mode decode and edge selection
// - decode high-speed and frequency output modes
// - decode eight and sixteen bit PWM
// - per-module enable gates event interrupt
// - capture loads counter and sets flag
// - event flag stays until software clears
// - software timer match sets event flag
// - low write clears, high write sets comparator
// - module two is watchdog after reset
`timescale 1ns/1ns
`include "cca_consts.vh"

module cca_top #(
    parameter NUM_MOD = 3,
    parameter WDT_MOD = 2
) (
    input  wire                 mclk,
    input  wire                 rst_n,
    input  wire [2:0]           timebase_select,
    input  wire                 idle_suspend,
    input  wire                 cpu_idle,
    input  wire                 counter_run,
    input  wire                 overflow_irq_enable,
    input  wire                 global_irq_enable,
    input  wire                 counter_array_irq_enable,
    input  wire                 timer0_overflow,
    input  wire                 external_count_input,
    input  wire                 ext_osc_div8,
    input  wire                 wdt_enable_wr,
    input  wire                 wdt_disable_wr,
    input  wire                 wdt_lock_wr,
    input  wire [7:0]           wdata,
    input  wire                 count_low_rd,
    input  wire                 count_high_rd,
    input  wire                 count_low_wr,
    input  wire                 count_high_wr,
    input  wire                 overflow_flag_clr,
    input  wire [NUM_MOD-1:0]   module_io_line,
    input  wire [NUM_MOD-1:0]   mode_wr,
    input  wire [NUM_MOD-1:0]   compare_low_wr,
    input  wire [NUM_MOD-1:0]   compare_high_wr,
    input  wire [NUM_MOD-1:0]   event_flag_clr,
    output reg  [7:0]           count_rd_data_q,
    output reg  [15:0]          counter_q,
    output reg                  counter_overflow_flag_q,
    output reg                  irq_q,
    output reg                  watchdog_active_q,
    output reg                  watchdog_reset_q,
    output reg  [2:0]           timebase_active_q,
    output reg                  idle_suspend_active_q,
    output wire [8*NUM_MOD-1:0] module_mode_q,
    output wire [16*NUM_MOD-1:0] capture_compare_q,
    output wire [NUM_MOD-1:0]   module_event_flag_q,
    output wire [3*NUM_MOD-1:0] module_op_q
);

////////////////////////////////////////////////////////////////////////////////

    reg  [3:0]         div12_q;
    reg  [3:0]         div4_q;
    reg                eci_q1;
    reg                eci_q2;
    reg                xo_s1;
    reg                xo_s2;
    reg                xo_s3;
    reg                adv_q;
    reg  [7:0]         snap_q;
    reg                wdt_lock_q;
    reg                tick;
    reg  [15:0]        counter_d;
    wire               tick12;
    wire               tick4;
    wire               eci_fall;
    wire               xo_rise;
    wire               run_eff;
    wire               idle_stop;
    wire               adv;
    wire               wrap;
    wire               lo_ovf;
    wire [NUM_MOD-1:0] wdt_trip;
    wire [NUM_MOD-1:0] mod_irq;
    wire               irq_d;

////////////////////////////////////////////////////////////////////////////////
// timebase sources

    // free-running prescalers, one-cycle enables
    assign tick12 = (div12_q == `CCA_DIV12_LAST);
    assign tick4  = (div4_q == `CCA_DIV4_LAST);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div12_q <= `CCA_DIV_RST;
            div4_q  <= `CCA_DIV_RST;
        end else begin
            div12_q <= tick12 ? `CCA_DIV_RST : div12_q + 4'h1;
            div4_q  <= tick4 ? `CCA_DIV_RST : div4_q + 4'h1;
        end
    end

    // edge on external input needs a low and high of two cycles each,
    // hence the quarter-rate ceiling on that source
    assign eci_fall = eci_q2 & ~eci_q1;

    // divided oscillator is foreign to mclk: two flops, then edge detect
    assign xo_rise = xo_s2 & ~xo_s3;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            eci_q1 <= 1'b0;
            eci_q2 <= 1'b0;
            xo_s1  <= 1'b0;
            xo_s2  <= 1'b0;
            xo_s3  <= 1'b0;
        end else begin
            eci_q1 <= external_count_input;
            eci_q2 <= eci_q1;
            xo_s1  <= ext_osc_div8;
            xo_s2  <= xo_s1;
            xo_s3  <= xo_s2;
        end
    end

    always @* begin
        case (timebase_active_q)
            `CCA_TB_DIV12:  tick = tick12;
            `CCA_TB_DIV4:   tick = tick4;
            `CCA_TB_T0OVF:  tick = timer0_overflow;
            `CCA_TB_ECI:    tick = eci_fall;
            `CCA_TB_SYSCLK: tick = 1'b1;
            `CCA_TB_XOSC8:  tick = xo_rise;
            default:        tick = 1'b0;
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// watchdog control and frozen configuration

    // lock keeps the watchdog on until the next reset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_active_q     <= `CCA_WDT_RST;
            wdt_lock_q            <= 1'b0;
            timebase_active_q     <= `CCA_TB_DIV12;
            idle_suspend_active_q <= 1'b0;
            watchdog_reset_q      <= 1'b0;
        end else begin
            if (wdt_lock_wr) begin
                wdt_lock_q        <= 1'b1;
                watchdog_active_q <= 1'b1;
            end else if (wdt_enable_wr) begin
                watchdog_active_q <= 1'b1;
            end else if (wdt_disable_wr && !wdt_lock_q) begin
                watchdog_active_q <= 1'b0;
            end
            if (!watchdog_active_q) begin
                timebase_active_q     <= timebase_select;
                idle_suspend_active_q <= idle_suspend;
            end
            watchdog_reset_q <= |wdt_trip;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// counter

    // watchdog forces the counter on regardless of run control
    assign run_eff   = counter_run | watchdog_active_q;
    assign idle_stop = idle_suspend_active_q & cpu_idle;
    assign adv       = run_eff & ~idle_stop & tick;
    assign wrap      = adv & (counter_q == `CCA_CNT_MAX);
    assign lo_ovf    = adv & (counter_q[7:0] == `CCA_BYTE_MAX);

    always @* begin
        counter_d = counter_q;
        if (adv)
            counter_d = counter_q + 16'h0001;
        // byte writes win over counting, refused while watchdog runs
        if (count_low_wr && !watchdog_active_q)
            counter_d[7:0] = wdata;
        if (count_high_wr && !watchdog_active_q)
            counter_d[15:8] = wdata;
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            counter_q               <= `CCA_CNT_RST;
            adv_q                   <= 1'b0;
            counter_overflow_flag_q <= 1'b0;
        end else begin
            counter_q               <= counter_d;
            adv_q                   <= adv;
            // set beats a same-cycle clear
            counter_overflow_flag_q <= wrap | (counter_overflow_flag_q & ~overflow_flag_clr);
        end
    end

////////////////////////////////////////////////////////////////////////////////
// coherent byte reads

    // reads only touch the snapshot and read data, never the counter
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            snap_q          <= `CCA_BYTE_RST;
            count_rd_data_q <= `CCA_BYTE_RST;
        end else begin
            if (count_low_rd) begin
                snap_q          <= counter_q[15:8];
                count_rd_data_q <= counter_q[7:0];
            end else if (count_high_rd) begin
                count_rd_data_q <= snap_q;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// capture/compare modules

    genvar gi;
    generate
        for (gi = 0; gi < NUM_MOD; gi = gi + 1) begin : g_mod
            cca_ccm #(
                .IS_WDT (gi == WDT_MOD)
            ) u_ccm (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .count      (counter_q),
                .adv_q      (adv_q),
                .lo_ovf     (lo_ovf),
                .io_line    (module_io_line[gi]),
                .wdata      (wdata),
                .mode_wr    (mode_wr[gi]),
                .lo_wr      (compare_low_wr[gi]),
                .hi_wr      (compare_high_wr[gi]),
                .flag_clr   (event_flag_clr[gi]),
                .wdt_active (watchdog_active_q),
                .mode_q     (module_mode_q[8*gi+7:8*gi]),
                .cc_q       (capture_compare_q[16*gi+15:16*gi]),
                .flag_q     (module_event_flag_q[gi]),
                .op_q       (module_op_q[3*gi+2:3*gi]),
                .wdt_trip   (wdt_trip[gi])
            );
            assign mod_irq[gi] = module_event_flag_q[gi] & module_mode_q[8*gi+`CCA_M_ECCF];
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// interrupt request

    assign irq_d = global_irq_enable & counter_array_irq_enable &
                   ((counter_overflow_flag_q & overflow_irq_enable) | (|mod_irq));

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            irq_q <= 1'b0;
        else
            irq_q <= irq_d;
    end

endmodule

// File: cca_top_props.sv
`timescale 1ns/1ns
module cca_top_props #(
    parameter NUM_MOD = 3,
    parameter WDT_MOD = 2
) (
    input wire                    mclk,
    input wire                    rst_n,
    input wire [15:0]             counter_q,
    input wire                    count_low_wr,
    input wire                    count_high_wr,
    input wire                    count_low_rd,
    input wire [7:0]              count_rd_data_q,
    input wire                    counter_overflow_flag_q,
    input wire                    overflow_flag_clr,
    input wire                    irq_q,
    input wire                    global_irq_enable,
    input wire                    counter_array_irq_enable,
    input wire                    overflow_irq_enable,
    input wire [NUM_MOD-1:0]      module_event_flag_q,
    input wire [NUM_MOD-1:0]      event_flag_clr,
    input wire [8*NUM_MOD-1:0]    module_mode_q,
    input wire [NUM_MOD-1:0]      mode_wr,
    input wire [NUM_MOD-1:0]      compare_low_wr,
    input wire [NUM_MOD-1:0]      compare_high_wr,
    input wire [7:0]              wdata,
    input wire [16*NUM_MOD-1:0]   capture_compare_q,
    input wire                    idle_suspend_active_q,
    input wire                    cpu_idle,
    input wire                    watchdog_active_q,
    input wire                    watchdog_reset_q,
    input wire [3*NUM_MOD-1:0]    module_op_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    property p_wrap;
        counter_q == 16'hFFFF ##1 counter_q == 16'h0000 |-> counter_overflow_flag_q;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap left overflow flag clear");
    property p_ovf_sticky;
        counter_overflow_flag_q && !overflow_flag_clr |=> counter_overflow_flag_q;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
    property p_irq;
        1 |=> irq_q == $past(global_irq_enable & counter_array_irq_enable & ((counter_overflow_flag_q &
            overflow_irq_enable) | (|(module_event_flag_q & {module_mode_q[16], module_mode_q[8], module_mode_q[0]}))));
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow flags and enables");
    property p_evt_sticky;
        1 |=> (module_event_flag_q & $past(module_event_flag_q & ~event_flag_clr))
            == $past(module_event_flag_q & ~event_flag_clr);
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("event flag dropped");
    property p_cc_low;
        compare_low_wr[1] && !compare_high_wr[1] && !mode_wr[1]
            |=> !module_mode_q[14] && capture_compare_q[23:16] == $past(wdata);
    endproperty
    a_cc_low: assert property (p_cc_low) else $error("low compare write wrong");
    property p_cc_high;
        compare_high_wr[1] && !compare_low_wr[1] && !mode_wr[1]
            |=> module_mode_q[14] && capture_compare_q[31:24] == $past(wdata);
    endproperty
    a_cc_high: assert property (p_cc_high) else $error("high compare write wrong");
    property p_step;
        !count_low_wr && !count_high_wr |=> (counter_q - $past(counter_q)) <= 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("counter moved by more than one");
    property p_low_rd;
        count_low_rd |=> count_rd_data_q == $past(counter_q[7:0]);
    endproperty
    a_low_rd: assert property (p_low_rd) else $error("low byte read wrong");
    property p_idle;
        idle_suspend_active_q && cpu_idle && !count_low_wr && !count_high_wr |=> $stable(counter_q);
    endproperty
    a_idle: assert property (p_idle) else $error("counter ran while suspended");
    property p_wdt_mode;
        // decode is registered: allow one cycle after the watchdog turns on
        watchdog_active_q && $past(watchdog_active_q) && $past(rst_n) |-> module_op_q[8:6] == 3'h2;
    endproperty
    a_wdt_mode: assert property (p_wdt_mode) else $error("module two not software timer");
    property p_wdt_pulse;
        $rose(watchdog_reset_q) |=> !watchdog_reset_q;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog reset too long");
endmodule

bind cca_top cca_top_props #(.NUM_MOD(NUM_MOD), .WDT_MOD(WDT_MOD)) u_props (.*);

// File: test_cca_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITF(c, n) begin for (k = 0; k < (n) && (c) !== 1'b1; k++) cyc(1); \
    if ((c) !== 1'b1) begin n_errors++; report_and_stop(); end end
module test_cca_top;
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic [2:0]  timebase_select = 3'h0;
    logic        idle_suspend = 1'b0, cpu_idle = 1'b0, counter_run = 1'b0, timer0_overflow = 1'b0;
    logic        overflow_irq_enable = 1'b0, global_irq_enable = 1'b0, counter_array_irq_enable = 1'b0;
    logic        wdt_enable_wr = 1'b0, wdt_disable_wr = 1'b0, wdt_lock_wr = 1'b0, overflow_flag_clr = 1'b0;
    logic        count_low_rd = 1'b0, count_high_rd = 1'b0, count_low_wr = 1'b0, count_high_wr = 1'b0;
    logic [7:0]  wdata = 8'h00, b;
    logic [2:0]  mode_wr = 3'h0, compare_low_wr = 3'h0, compare_high_wr = 3'h0, event_flag_clr = 3'h0;
    wire  [2:0]  module_io_line;
    wire         external_count_input, ext_osc_div8;
    logic [7:0]  count_rd_data_q;
    logic [15:0] counter_q;
    logic        counter_overflow_flag_q, irq_q, watchdog_active_q, watchdog_reset_q, idle_suspend_active_q;
    logic [2:0]  timebase_active_q, module_event_flag_q;
    logic [23:0] module_mode_q;
    logic [47:0] capture_compare_q;
    logic [8:0]  module_op_q;
    logic [7:0]  modes [8] = '{8'h20, 8'h10, 8'h30, 8'h48, 8'h4C, 8'h46, 8'hC2, 8'h42};
    logic [2:0]  ops [8] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h5};
    int          n_errors = 0, comparisons = 0, k, i;

    cca_top dut (.*);
    cca_ext_model u_ext (.*);
    always #50 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task wr_cnt(input logic [15:0] v);
        wdata = v[7:0];
        count_low_wr = 1'b1;
        cyc(1);
        count_low_wr = 1'b0;
        wdata = v[15:8];
        count_high_wr = 1'b1;
        cyc(1);
        count_high_wr = 1'b0;
        cyc(1);
    endtask
    task rd(input bit hi, output logic [7:0] v);
        if (hi) count_high_rd = 1'b1;
        else count_low_rd = 1'b1;
        cyc(1);
        count_high_rd = 1'b0;
        count_low_rd = 1'b0;
        v = count_rd_data_q;
        cyc(1);
    endtask
    task wr_mode(input int m, input logic [7:0] v);
        mode_wr[m] = 1'b1;
        wdata = v;
        cyc(1);
        mode_wr = 3'h0;
        cyc(1);
    endtask
    task wr_cc(input int m, input bit hi, input logic [7:0] v);
        if (hi) compare_high_wr[m] = 1'b1;
        else compare_low_wr[m] = 1'b1;
        wdata = v;
        cyc(1);
        compare_high_wr = 3'h0;
        compare_low_wr = 3'h0;
        cyc(1);
    endtask
    task tb_start(input logic [2:0] code);
        timebase_select = code;
        counter_run = 1'b0;
        wr_cnt(16'h0000);
        counter_run = 1'b1;
    endtask
    task tb_stop(input logic [15:0] lo, input logic [15:0] hi);
        counter_run = 1'b0;
        cyc(2);
        `CHK(counter_q >= lo && counter_q <= hi, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        cyc(2);
        `CHK(watchdog_active_q, 1'b1)
        `CHK(module_op_q[8:6], 3'h2)
        wr_cnt(16'hAAAA);
        // a refused write keeps the high byte at zero, so the first low-byte overflow trips
        `WAITF(watchdog_reset_q, 3300)
        `CHK(counter_q, 16'h0100)
        wdt_disable_wr = 1'b1;
        cyc(1);
        wdt_disable_wr = 1'b0;
        cyc(1);
        `CHK(watchdog_active_q, 1'b0)
        wr_cnt(16'hA55A);
        rd(1'b0, b);
        `CHK(b, 8'h5A)
        wr_cnt(16'h3C00);
        rd(1'b1, b);
        `CHK(b, 8'hA5)
        `CHK(counter_q, 16'h3C00)
        tb_start(3'h4);
        cyc(48);
        tb_stop(47, 49);
        tb_start(3'h1);
        cyc(48);
        tb_stop(11, 13);
        tb_start(3'h0);
        cyc(48);
        tb_stop(3, 5);
        tb_start(3'h6);
        cyc(20);
        tb_stop(0, 0);
        tb_start(3'h2);
        for (i = 0; i < 3; i++) begin
            timer0_overflow = 1'b1;
            cyc(1);
            timer0_overflow = 1'b0;
            cyc(1);
        end
        tb_stop(3, 3);
        tb_start(3'h3);
        u_ext.eci_falls(5);
        cyc(3);
        tb_stop(5, 5);
        tb_start(3'h5);
        u_ext.osc_rises(4);
        cyc(4);
        tb_stop(4, 4);
        idle_suspend = 1'b1;
        cpu_idle = 1'b1;
        tb_start(3'h4);
        cyc(20);
        `CHK(idle_suspend_active_q, 1'b1)
        tb_stop(0, 1);
        idle_suspend = 1'b0;
        cyc(2);
        tb_start(3'h4);
        cyc(20);
        tb_stop(19, 21);
        cpu_idle = 1'b0;
        wr_cnt(16'hFFFE);
        overflow_irq_enable = 1'b1;
        global_irq_enable = 1'b1;
        counter_array_irq_enable = 1'b1;
        counter_run = 1'b1;
        `WAITF(counter_overflow_flag_q, 10)
        counter_run = 1'b0;
        `CHK(counter_q <= 16'h0002, 1'b1)
        cyc(2);
        `CHK(irq_q, 1'b1)
        overflow_irq_enable = 1'b0;
        cyc(2);
        `CHK(irq_q, 1'b0)
        overflow_irq_enable = 1'b1;
        global_irq_enable = 1'b0;
        cyc(2);
        `CHK(irq_q, 1'b0)
        global_irq_enable = 1'b1;
        `CHK(counter_overflow_flag_q, 1'b1)
        overflow_flag_clr = 1'b1;
        cyc(1);
        overflow_flag_clr = 1'b0;
        cyc(1);
        `CHK(counter_overflow_flag_q, 1'b0)
        for (i = 0; i < 8; i++) begin
            wr_mode(0, modes[i]);
            cyc(1);
            `CHK(module_op_q[2:0], ops[i])
        end
        wr_cnt(16'h4321);
        wr_mode(0, 8'h21);
        wr_mode(1, 8'h10);
        u_ext.io_set(0, 1'b1);
        `CHK(module_event_flag_q[0], 1'b1)
        `CHK(capture_compare_q[15:0], 16'h4321)
        u_ext.io_set(1, 1'b1);
        `CHK(module_event_flag_q[1], 1'b0)
        u_ext.io_set(1, 1'b0);
        `CHK(module_event_flag_q[1], 1'b1)
        `CHK(irq_q, 1'b1)
        event_flag_clr = 3'h1;
        cyc(1);
        event_flag_clr = 3'h0;
        cyc(2);
        `CHK(module_event_flag_q, 3'h2)
        `CHK(irq_q, 1'b0)
        event_flag_clr = 3'h2;
        cyc(1);
        event_flag_clr = 3'h0;
        wr_mode(1, 8'h48);
        wr_cc(1, 1'b0, 8'h34);
        `CHK(module_mode_q[14], 1'b0)
        wr_cc(1, 1'b1, 8'h12);
        `CHK(module_mode_q[14], 1'b1)
        `CHK(capture_compare_q[31:16], 16'h1234)
        wr_cnt(16'h1230);
        counter_run = 1'b1;
        `WAITF(module_event_flag_q[1], 20)
        `CHK(counter_q, 16'h1235)
        counter_run = 1'b0;
        // re-enable, disable, then lock: a later disable and timebase change are refused
        wdt_enable_wr = 1'b1;
        cyc(1);
        wdt_enable_wr = 1'b0;
        cyc(2);
        `CHK(module_op_q[8:6], 3'h2)
        wdt_disable_wr = 1'b1;
        cyc(1);
        wdt_disable_wr = 1'b0;
        wdt_lock_wr = 1'b1;
        cyc(1);
        wdt_lock_wr = 1'b0;
        wdt_disable_wr = 1'b1;
        timebase_select = 3'h0;
        cyc(1);
        wdt_disable_wr = 1'b0;
        cyc(1);
        `CHK(watchdog_active_q, 1'b1)
        `CHK(timebase_active_q, 3'h4)
        report_and_stop();
    end
endmodule
